// File: serial_port_defines.svh
// Register map, field positions, reset values and bit periods
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

// Register indices; byte address is four times the index
`define CTRL_IDX 30'h0000_0006
`define DATA_IDX 30'h0000_0007
`define MODE_IDX 30'h0000_0008

// Only whole-word transfers change registers
`define WORD_SIZE 3'h2

// Control register fields
`define RXDONE_POS 0
`define TXDONE_POS 1
`define RXNINTH_POS 2
`define TXNINTH_POS 3
`define RXEN_POS 4
`define MPMODE_POS 5
`define MODEONE_POS 6
`define MODEZERO_POS 7

// Mode register fields
`define FRMCHK_POS 0
`define RATESEL_POS 1

// Reset values
`define CTRL_RESET 8'h00
`define DATA_RESET 8'h00
`define MODE_RESET 8'h00

// Bit periods in clock units
`define PER_SYNC_SLOW 7'h0C
`define PER_SYNC_FAST 7'h04
`define PER_FAST_BAUD 7'h10
`define PER_FAST_SYS 7'h20
`define PER_SLOW 7'h40

`endif

// File: serial_port_pkg.sv
// Shared types of the serial port
package serial_port_pkg;
    // Operating modes, coded as {mode bit zero, mode bit one}
    typedef enum logic [1:0] {
        MODE_SYNC = 2'b00,
        MODE_ASYNC10 = 2'b01,
        MODE_SYS11 = 2'b10,
        MODE_BAUD11 = 2'b11
    } mode_t;

    // Receiver states, Gray along idle-start-data-stop
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } rx_state_t;

    // Transmitter states, Gray along idle-start-bits-stop
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_BITS = 2'b11,
        TX_STOP = 2'b10
    } tx_state_t;
endpackage

// File: serial_link_if.sv
// Signals between the serial port control and its two shifters
interface serial_link_if;
    logic unitTick;
    logic [6:0] period;
    serial_port_pkg::mode_t mode;
    logic multiproc;
    logic txStart;
    logic [7:0] txData;
    logic txNinth;
    logic txBusy;
    logic txDone;
    logic txLine;
    logic txShiftClk;
    logic rxEnable;
    logic rxStart;
    logic rxLine;
    logic rxDone;
    logic rxFrameErr;
    logic rxNinth;
    logic [7:0] rxData;
    logic rxShiftClk;

    // Transmit shifter side
    modport tx(input unitTick, period, mode, txStart, txData, txNinth,
        output txBusy, txDone, txLine, txShiftClk);
    // Receive shifter side
    modport rx(input unitTick, period, mode, multiproc, rxEnable, rxStart,
        rxLine, output rxDone, rxFrameErr, rxNinth, rxData, rxShiftClk);
endinterface

// File: serial_tx.sv
// Transmit shifter for all four serial modes
module serial_tx (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link to the control block
    serial_link_if.tx link
);
    serial_port_pkg::tx_state_t state;
    logic [6:0] cnt;
    logic [3:0] bitNum;
    logic [8:0] shReg;
    logic ninthSnap;

    // Period boundary and frame shape
    wire isSync = link.mode == serial_port_pkg::MODE_SYNC;
    wire hasNinth = link.mode[1];
    wire [3:0] lastBit = hasNinth ? 4'h8 : 4'h7;
    wire periodEnd = link.unitTick && (cnt == link.period - 7'h01);
    wire firstHalf = cnt < {1'b0, link.period[6:1]};
    wire inBits = state == serial_port_pkg::TX_BITS;

    // Line level and shift clock, low in first half of each bit in synchronous mode
    assign link.txBusy = state != serial_port_pkg::TX_IDLE;
    assign link.txLine = (state == serial_port_pkg::TX_START) ? 1'b0 :
        inBits ? shReg[0] : 1'b1;
    assign link.txShiftClk = !(isSync && inBits && firstHalf);

    // Unit counter restarts at each bit boundary
    always_ff @(posedge clk) begin
        if (rst || !link.txBusy || periodEnd)
            cnt <= 7'h00;
        else if (link.unitTick)
            cnt <= cnt + 7'h01;
    end

    // Frame sequencer
    always_ff @(posedge clk) begin
        link.txDone <= 1'b0;
        if (rst) begin
            state <= serial_port_pkg::TX_IDLE;
            bitNum <= 4'h0;
            shReg <= 9'h000;
            ninthSnap <= 1'b0;
        end else begin
            unique case (state)
                serial_port_pkg::TX_IDLE: if (link.txStart) begin
                    // R9 ninth bit loaded
                    shReg <= {link.txNinth, link.txData};
                    ninthSnap <= link.txNinth;
                    bitNum <= 4'h0;
                    state <= isSync ? serial_port_pkg::TX_BITS :
                        serial_port_pkg::TX_START;
                end
                serial_port_pkg::TX_START: if (periodEnd) begin
                    state <= serial_port_pkg::TX_BITS;
                end
                serial_port_pkg::TX_BITS: if (periodEnd) begin
                    shReg <= {1'b0, shReg[8:1]};
                    bitNum <= bitNum + 4'h1;
                    if (bitNum == lastBit) begin
                        // R6 done after last data bit
                        link.txDone <= 1'b1;
                        state <= isSync ? serial_port_pkg::TX_IDLE :
                            serial_port_pkg::TX_STOP;
                    end
                end
                serial_port_pkg::TX_STOP: if (periodEnd) begin
                    state <= serial_port_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // R9 ninth bit slot
    sequence s_ninth_slot;
        inBits && bitNum == 4'h8;
    endsequence
    a_ninth_bit_out: assert property (@(posedge clk) disable iff (rst) // R9
        s_ninth_slot |-> link.txLine == ninthSnap)
        else $error("ninth bit slot does not carry the stored ninth bit");
endmodule

// File: serial_rx.sv
// Receive shifter with start check, ninth bit and address filter
module serial_rx (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link to the control block
    serial_link_if.rx link
);
    serial_port_pkg::rx_state_t state;
    logic [6:0] cnt;
    logic [3:0] bitNum;
    logic [8:0] shReg;

    // Sampling points and frame shape
    wire isSync = link.mode == serial_port_pkg::MODE_SYNC;
    wire hasNinth = link.mode[1];
    wire [3:0] lastBit = hasNinth ? 4'h8 : 4'h7;
    wire [6:0] halfPer = {1'b0, link.period[6:1]};
    wire periodEnd = link.unitTick && (cnt == link.period - 7'h01);
    wire halfEnd = link.unitTick && (cnt == halfPer - 7'h01);
    wire idle = state == serial_port_pkg::RX_IDLE;
    wire inData = state == serial_port_pkg::RX_DATA;
    wire halt = !link.rxEnable && !idle;
    wire [8:0] nextSh = {link.rxLine, shReg[8:1]};
    wire [7:0] gotData = hasNinth ? nextSh[7:0] : nextSh[8:1];
    wire mpBlock = link.multiproc && !link.rxLine;
    wire lastData = inData && periodEnd && bitNum == lastBit;
    assign link.rxShiftClk = !(isSync && inData && cnt < halfPer);

    // Unit counter, realigned to mid-bit after the start check
    always_ff @(posedge clk) begin
        if (rst || idle || periodEnd ||
            (state == serial_port_pkg::RX_START && halfEnd))
            cnt <= 7'h00;
        else if (link.unitTick)
            cnt <= cnt + 7'h01;
    end

    // Frame sequencer
    always_ff @(posedge clk) begin
        link.rxDone <= 1'b0;
        link.rxFrameErr <= 1'b0;
        if (rst) begin
            state <= serial_port_pkg::RX_IDLE;
            bitNum <= 4'h0;
            shReg <= 9'h000;
            link.rxData <= 8'h00;
            link.rxNinth <= 1'b0;
        end else if (halt) begin
            // R10 receiver off drops frame
            state <= serial_port_pkg::RX_IDLE;
        end else begin
            unique case (state)
                serial_port_pkg::RX_IDLE: begin
                    bitNum <= 4'h0;
                    // R11 enable starts reception
                    if (isSync && link.rxStart)
                        state <= serial_port_pkg::RX_DATA;
                    else if (!isSync && link.rxEnable && !link.rxLine)
                        state <= serial_port_pkg::RX_START;
                end
                serial_port_pkg::RX_START: if (halfEnd) begin
                    state <= link.rxLine ? serial_port_pkg::RX_IDLE :
                        serial_port_pkg::RX_DATA;
                end
                serial_port_pkg::RX_DATA: if (periodEnd) begin
                    shReg <= nextSh;
                    bitNum <= bitNum + 4'h1;
                    if (bitNum == lastBit) begin
                        state <= isSync ? serial_port_pkg::RX_IDLE :
                            serial_port_pkg::RX_STOP;
                        // R2 R4 R7 R13 done on last bit
                        if (isSync || (hasNinth && !mpBlock)) begin
                            link.rxDone <= 1'b1;
                            link.rxData <= gotData;
                            link.rxNinth <= link.rxLine;
                        end
                    end
                end
                serial_port_pkg::RX_STOP: if (periodEnd) begin
                    state <= serial_port_pkg::RX_IDLE;
                    link.rxFrameErr <= !link.rxLine;
                    // R3 R8 R12 stop bit decides
                    if (!hasNinth && !mpBlock) begin
                        link.rxDone <= 1'b1;
                        link.rxData <= shReg[8:1];
                        link.rxNinth <= link.rxLine;
                    end
                end
            endcase
        end
    end

    // R2 sync done after eighth
    sequence s_eighth_bit;
        isSync && lastData && !halt;
    endsequence
    a_sync_rx_done: assert property (@(posedge clk) disable iff (rst) // R2
        s_eighth_bit |=> link.rxDone)
        else $error("sync receive did not finish after eighth bit");

    // R10 disabled receiver idles
    a_rx_disabled: assert property (@(posedge clk) disable iff (rst) // R10
        !link.rxEnable |=> idle && !link.rxDone)
        else $error("receiver active while disabled");

    // R13 address filter
    a_mp_filter: assert property (@(posedge clk) disable iff (rst) // R13
        hasNinth && link.multiproc && lastData && !link.rxLine
        |=> !link.rxDone)
        else $error("address filter let a data frame through");

    // R12 bad stop discarded
    a_stop_filter: assert property (@(posedge clk) disable iff (rst) // R12
        link.mode == serial_port_pkg::MODE_ASYNC10 && link.multiproc &&
        state == serial_port_pkg::RX_STOP && periodEnd && !halt &&
        !link.rxLine |=> !link.rxDone && link.rxFrameErr)
        else $error("frame with bad stop bit was accepted");
endmodule

// File: serial_port_control.sv
// Serial port control, status and data registers on an AHB-Lite slave
//
// Operation
// R1: Any reset clears the whole control register to zero.
// R2: Synchronous mode sets receive-done at the end of the eighth bit.
// R3: Ten-bit mode sets receive-done after the stop sample, subject to multiproc bit.
// R4: Eleven-bit modes set receive-done after the ninth bit sample.
// R5: Receive-done stays set until software writes it to zero.
// R6: Transmit-done sets after the last data bit; holds until software clears.
// R7: Eleven-bit modes store the received ninth bit.
// R8: Ten-bit mode with multiproc bit zero stores the stop bit there.
// R9: Eleven-bit modes send the transmit ninth bit as ninth frame bit.
// R10: Receive-enable zero keeps the receiver off and accepts nothing.
// R11: Receive-enable one enables async reception or starts a synchronous receive.
// R12: Ten-bit mode with multiproc bit set drops frames with bad stop.
// R13: Multiproc eleven-bit modes drop frames whose ninth bit is zero.
// R14: Synchronous shift clock divides by twelve, or by four with multiproc bit.
// R15: Control bits: done flags 0-1, ninth bits 2-3, enable 4, modes 5-7.
// R16: Mode bits pick synchronous, ten-bit baud, eleven-bit system or baud.
// R17: With framing check, bit seven is a sticky framing error flag.
// R18: Rate select picks bit period 16, 32 or 64 clocks.
// R19: One data address: writes feed transmitter, reads return receive buffer.
// R20: A hardware flag set beats a same-cycle software clear.
`include "serial_port_defines.svh"

module serial_port_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial pins
    input wire logic baudClk,
    input wire logic rxd,
    output logic txd,
    output logic shiftClk
);
    serial_link_if link();

    // Pin synchronisers and baud edge
    logic rxdMeta;
    logic rxdSync;
    logic baudMeta;
    logic baudSync;
    logic baudPrev;

    // Control register fields
    logic rxDoneFlag;
    logic txDoneFlag;
    logic rxNinthBit;
    logic txNinthBit;
    logic rxEnable;
    logic multiprocModeBit;
    logic modeBitOne;
    logic modeBitZero;
    logic framingErrorFlag;

    // Mode register fields and receive buffer
    logic framingCheckEnable;
    logic rateSelect;
    logic [7:0] rxBuf;

    // Bus data phase state
    logic wrPend;
    logic rdPend;
    logic [29:0] regIdx;

    // Bus decode
    wire reqTaken = hsel && hready && htrans[1];
    wire wrCtrl = wrPend && regIdx == `CTRL_IDX;
    wire wrData = wrPend && regIdx == `DATA_IDX;
    wire wrMode = wrPend && regIdx == `MODE_IDX;
    wire [7:0] wByte = hwdata[7:0];

    // R15 control bit places
    wire bitSeven = framingCheckEnable ? framingErrorFlag : modeBitZero;
    wire [7:0] ctrlValue = {bitSeven, modeBitOne, multiprocModeBit,
        rxEnable, txNinthBit, rxNinthBit, txDoneFlag, rxDoneFlag};
    wire [7:0] modeValue = {6'h00, rateSelect, framingCheckEnable};
    wire [7:0] modeReset = `MODE_RESET; // Low two bits kept

    // R19 reads return receive buffer
    wire [7:0] readByte = (regIdx == `CTRL_IDX) ? ctrlValue :
        (regIdx == `DATA_IDX) ? rxBuf :
        (regIdx == `MODE_IDX) ? modeValue : 8'h00;

    // R16 mode and clock source select
    serial_port_pkg::mode_t modeSel;
    assign modeSel = serial_port_pkg::mode_t'({modeBitZero, modeBitOne});
    wire isSync = modeSel == serial_port_pkg::MODE_SYNC;
    wire baudMode = modeSel == serial_port_pkg::MODE_ASYNC10 ||
        modeSel == serial_port_pkg::MODE_BAUD11;
    wire baudTick = baudSync && !baudPrev;

    // R14 R18 bit period select
    wire [6:0] syncPer = multiprocModeBit ? `PER_SYNC_FAST : `PER_SYNC_SLOW;
    wire [6:0] fastPer = baudMode ? `PER_FAST_BAUD : `PER_FAST_SYS;
    wire [6:0] asyncPer = rateSelect ? fastPer : `PER_SLOW;

    // Shifter link drive
    assign link.unitTick = baudMode ? baudTick : 1'b1;
    assign link.period = isSync ? syncPer : asyncPer;
    assign link.mode = modeSel;
    assign link.multiproc = multiprocModeBit;
    assign link.txStart = wrData && !link.txBusy;
    assign link.txData = wByte;
    assign link.txNinth = txNinthBit;
    assign link.rxEnable = rxEnable;
    assign link.rxLine = rxdSync;
    // R11 sync receive waits for clear flag
    assign link.rxStart = isSync && rxEnable && !rxDoneFlag &&
        !link.rxDone && !link.txBusy;

    // Framing error event, only while the check is on
    wire feSet = link.rxFrameErr && framingCheckEnable;

    serial_tx txUnit (
        .clk(clk),
        .rst(rst),
        .link(link)
    );

    serial_rx rxUnit (
        .clk(clk),
        .rst(rst),
        .link(link)
    );

    // Two-stage synchronisers for pins
    always_ff @(posedge clk) begin
        if (rst) begin
            rxdMeta <= 1'b1;
            rxdSync <= 1'b1;
            baudMeta <= 1'b0;
            baudSync <= 1'b0;
            baudPrev <= 1'b0;
        end else begin
            rxdMeta <= rxd;
            rxdSync <= rxdMeta;
            baudMeta <= baudClk;
            baudSync <= baudMeta;
            baudPrev <= baudSync;
        end
    end

    // Bus phases; reads take one wait state
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend <= 1'b0;
            rdPend <= 1'b0;
            regIdx <= 30'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            wrPend <= reqTaken && hwrite && hsize == `WORD_SIZE;
            rdPend <= reqTaken && !hwrite;
            hreadyout <= !(reqTaken && !hwrite);
            if (reqTaken)
                regIdx <= haddr[31:2];
            if (rdPend)
                hrdata <= {24'h00_0000, readByte};
        end
    end

    // R1 control fields cleared on reset
    always_ff @(posedge clk) begin
        if (rst) begin
            {modeBitZero, modeBitOne, multiprocModeBit, rxEnable,
                txNinthBit, rxNinthBit, txDoneFlag, rxDoneFlag} <= `CTRL_RESET;
            framingErrorFlag <= 1'b0;
        end else begin
            if (wrCtrl) begin
                rxEnable <= wByte[`RXEN_POS];
                txNinthBit <= wByte[`TXNINTH_POS];
                multiprocModeBit <= wByte[`MPMODE_POS];
                modeBitOne <= wByte[`MODEONE_POS];
            end
            // R17 bit seven leaves mode alone
            if (wrCtrl && !framingCheckEnable)
                modeBitZero <= wByte[`MODEZERO_POS];
            // R5 R20 receive flag, set wins
            rxDoneFlag <= link.rxDone ||
                (wrCtrl ? wByte[`RXDONE_POS] : rxDoneFlag);
            // R6 R20 transmit flag, set wins
            txDoneFlag <= link.txDone ||
                (wrCtrl ? wByte[`TXDONE_POS] : txDoneFlag);
            // R17 framing flag, set wins
            framingErrorFlag <= feSet ||
                ((wrCtrl && framingCheckEnable) ?
                wByte[`MODEZERO_POS] : framingErrorFlag);
            // R7 R8 ninth bit captured with data
            rxNinthBit <= link.rxDone ? link.rxNinth :
                (wrCtrl ? wByte[`RXNINTH_POS] : rxNinthBit);
        end
    end

    // Mode register and receive buffer
    always_ff @(posedge clk) begin
        if (rst) begin
            {framingCheckEnable, rateSelect} <= modeReset[1:0];
            rxBuf <= `DATA_RESET;
        end else begin
            if (wrMode) begin
                framingCheckEnable <= wByte[`FRMCHK_POS];
                rateSelect <= wByte[`RATESEL_POS];
            end
            // R19 receive buffer loads
            if (link.rxDone)
                rxBuf <= link.rxData;
        end
    end

    // Pin drivers, idle high
    always_ff @(posedge clk) begin
        if (rst) begin
            txd <= 1'b1;
            shiftClk <= 1'b1;
        end else begin
            txd <= link.txLine;
            shiftClk <= link.txShiftClk && link.rxShiftClk;
        end
    end

    // R1 reset clears control
    a_reset_clears: assert property (@(posedge clk) // R1
        rst |=> ctrlValue == `CTRL_RESET && !framingErrorFlag)
        else $error("control register not cleared by reset");

    // R5 receive flag sticky
    a_rx_flag_sticky: assert property (@(posedge clk) disable iff (rst) // R5
        rxDoneFlag && !wrCtrl |=> rxDoneFlag)
        else $error("receive-done flag dropped without a write");

    // R6 transmit flag set
    a_tx_flag_set: assert property (@(posedge clk) disable iff (rst) // R6
        link.txDone |=> txDoneFlag ##1 (txDoneFlag || $past(wrCtrl)))
        else $error("transmit-done flag not set or not held");

    // R20 set beats clear
    a_set_beats_clear: assert property (@(posedge clk) disable iff (rst) // R20
        link.rxDone && wrCtrl && !wByte[`RXDONE_POS] |=> rxDoneFlag)
        else $error("software clear hid a receive event");

    // R14 sync divisor
    a_sync_divisor: assert property (@(posedge clk) disable iff (rst) // R14
        isSync |-> (multiprocModeBit ? link.period == 7'h04 :
        link.period == 7'h0C) && link.unitTick)
        else $error("wrong synchronous shift divisor");

    // R18 rate select period
    a_rate_period: assert property (@(posedge clk) disable iff (rst) // R18
        !isSync |-> link.period == (!rateSelect ? 7'h40 :
        baudMode ? 7'h10 : 7'h20))
        else $error("wrong asynchronous bit period");

    // R16 baud clocked modes
    a_baud_source: assert property (@(posedge clk) disable iff (rst) // R16
        baudMode |-> link.unitTick == (baudSync && !baudPrev))
        else $error("baud-clocked mode not paced by baud clock");

    // R17 framing flag shows
    a_frame_flag: assert property (@(posedge clk) disable iff (rst) // R17
        feSet |=> ctrlValue[`MODEZERO_POS] && $stable(modeBitZero))
        else $error("framing error not shown in bit seven");

    // R19 separate buffers
    a_rx_buffer: assert property (@(posedge clk) disable iff (rst) // R19
        link.rxDone |=> rxBuf == $past(link.rxData))
        else $error("receive buffer not loaded with received byte");

    // R15 control read layout
    a_ctrl_read: assert property (@(posedge clk) disable iff (rst) // R15
        rdPend && regIdx == `CTRL_IDX && !wrPend
        |=> hrdata[0] == $past(rxDoneFlag) && hrdata[4] == $past(rxEnable)
        && hreadyout)
        else $error("control read returns wrong bit layout");

    // R6 transmit flag sticky
    a_tx_flag_sticky: assert property (@(posedge clk) disable iff (rst) // R6
        txDoneFlag && !wrCtrl |=> txDoneFlag)
        else $error("transmit-done flag dropped without a write");

    // R20 transmit set beats clear
    a_tx_set_wins: assert property (@(posedge clk) disable iff (rst) // R20
        link.txDone && wrCtrl && !wByte[`TXDONE_POS] |=> txDoneFlag)
        else $error("software clear hid a transmit event");

    // R19 data write starts sender
    a_tx_load: assert property (@(posedge clk) disable iff (rst) // R19
        wrData && !link.txBusy |=> link.txBusy)
        else $error("data write did not start transmitter");

    // R17 flag write keeps mode
    a_fe_write: assert property (@(posedge clk) disable iff (rst) // R17
        wrCtrl && framingCheckEnable |=> $stable(modeBitZero))
        else $error("framing flag write changed the mode");
endmodule

// File: serial_peer.sv
// Remote serial peer that sends and captures eleven-bit frames
module serial_peer (
    // Clock
    input wire logic clk,
    // Serial lines
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    // Line idles high between frames
    initial rxd = 1'b1;
    // Start, data LSB first, ninth bit, stop
    task automatic send(input logic [8:0] w, input int per);
        logic [10:0] f;
        f = {1'b1, w, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (per) @(posedge clk);
        end
    endtask
    // Find the start edge, then sample each bit centre
    task automatic recv(output logic [8:0] w, input int per);
        w = '0;
        while (txd !== 1'b0) @(posedge clk);
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (per) @(posedge clk);
            w[i] = txd;
        end
    endtask
endmodule

// File: serial_port_control_test.sv
// Self-checking bench for the serial port control block
`include "serial_port_defines.svh"
module serial_port_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] CTRL = {`CTRL_IDX, 2'b00};
    localparam logic [31:0] DATA = {`DATA_IDX, 2'b00};
    localparam logic [31:0] MODE = {`MODE_IDX, 2'b00};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic baudClk = 1'b0;
    logic hreadyout, hresp, txd, shiftClk, rxd;
    logic [31:0] hrdata;
    int nFail = 0;
    int cmpCount = 0;
    // Device under test and its remote peer
    serial_port_control serial_port_control_i (.clk(clk), .rst(rst),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(`WORD_SIZE), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .baudClk(baudClk), .rxd(rxd), .txd(txd), .shiftClk(shiftClk));
    serial_peer serial_peer_i (.clk(clk), .txd(txd), .rxd(rxd));
    // Clock, baud clock and watchdog
    initial forever #50 clk = ~clk;
    always @(posedge clk) baudClk <= ~baudClk;
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        tally_and_finish();
    end
    // One AHB-Lite single transfer
    task automatic bus(input logic wr, input logic [31:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
            input string nm);
        cmpCount++;
        if (g !== e) begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, a, {24'h00_0000, d}, x);
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] m,
            input logic [7:0] e, input string nm);
        logic [31:0] x;
        bus(1'b0, a, '0, x);
        chk(x & {24'hFF_FFFF, m}, {24'h00_0000, e}, nm);
        chk({31'h0000_0000, hresp}, 32'h0000_0000, "hresp");
    endtask
    // Reset values, field places, unmapped address, rate select
    task automatic testRegs();
        rd(CTRL, 8'hFF, 8'h00, "ctrl reset");
        rd(MODE, 8'hFF, 8'h00, "mode reset");
        wr(CTRL, 8'h08);
        rd(CTRL, 8'hFF, 8'h08, "tx ninth place");
        rd(32'h0000_0024, 8'hFF, 8'h00, "unmapped");
        wr(MODE, 8'h02);
        rd(MODE, 8'hFF, 8'h02, "rate select");
    endtask
    // Synchronous receive at divide-by-four, shift clock low cycles
    task automatic testSync();
        int n = 0;
        wr(CTRL, 8'h30);
        repeat (60) begin
            @(posedge clk);
            if (shiftClk == 1'b0)
                n++;
        end
        chk(n, 16, "shift clock low cycles");
        rd(CTRL, 8'hFB, 8'h31, "sync rx done");
        rd(DATA, 8'hFF, 8'hFF, "sync rx data");
    endtask
    // Ten-bit baud-clocked receive, stop check and framing flag
    task automatic testTen();
        wr(CTRL, 8'h70);
        serial_peer_i.send({1'b1, 8'h3C}, 32);
        rd(CTRL, 8'hFF, 8'h75, "ten-bit done and stop");
        wr(MODE, 8'h03);
        wr(CTRL, 8'h70);
        serial_peer_i.send({1'b0, 8'hC3}, 32);
        rd(CTRL, 8'hFF, 8'hF0, "bad stop dropped");
        rd(DATA, 8'hFF, 8'h3C, "ten-bit data kept");
        wr(CTRL, 8'h00);
        wr(MODE, 8'h02);
    endtask
    // Eleven-bit receive, held flag, address filter, disabled receiver
    task automatic testRx();
        wr(CTRL, 8'h90);
        serial_peer_i.send({1'b1, 8'hA5}, 32);
        repeat (40) @(posedge clk);
        rd(CTRL, 8'hFF, 8'h95, "rx done and ninth");
        rd(DATA, 8'hFF, 8'hA5, "rx data");
        wr(CTRL, 8'hB0);
        serial_peer_i.send({1'b0, 8'h5A}, 32);
        repeat (40) @(posedge clk);
        rd(CTRL, 8'hFB, 8'hB0, "filtered frame");
        serial_peer_i.send({1'b1, 8'h77}, 32);
        repeat (40) @(posedge clk);
        rd(CTRL, 8'hFF, 8'hB5, "address frame");
        rd(DATA, 8'hFF, 8'h77, "address data");
        wr(CTRL, 8'h80);
        serial_peer_i.send({1'b1, 8'h11}, 32);
        repeat (40) @(posedge clk);
        rd(CTRL, 8'hFF, 8'h80, "rx disabled");
        rd(DATA, 8'hFF, 8'h77, "data kept");
    endtask
    // Eleven-bit transmit with a given ninth bit
    task automatic testTx(input logic nb, input logic [7:0] d);
        logic [8:0] w;
        wr(CTRL, {4'h8, nb, 3'h0});
        fork
            serial_peer_i.recv(w, 32);
            wr(DATA, d);
        join
        chk({23'h00_0000, w}, {23'h00_0000, nb, d}, "tx frame");
        repeat (40) @(posedge clk);
        rd(CTRL, 8'hFF, {4'h8, nb, 3'h2}, "tx done");
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Reset, then the scenarios in turn
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        testRegs();
        testSync();
        testTen();
        testRx();
        testTx(1'b1, 8'h3C);
        testTx(1'b0, 8'hC3);
        tally_and_finish();
    end
endmodule
